// File: design/vic_edge_det.sv
// Port pin synchroniser and edge detector with sticky per-pin status
`timescale 1ns/1ps
module vic_edge_det #(
    parameter int W = 46
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] pins_in,
    vic_edge_if.det           eif
);
    // ==========================================================
    // Synchroniser
    logic [W-1:0] s1_r;     // First stage, read only by s2
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] lvl_r;    // Accepted level once s2 and s3 agree
    logic [W-1:0] pend_r;   // Sticky edge status

    // Three-stage chain; a change counts when stage two and three agree
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
        end else begin
            s1_r  <= pins_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
        end
    end

    // ==========================================================
    // Edge detection, per pin
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pin
            logic agree;
            logic rise;
            logic fall;
            assign agree = (s2_r[g] == s3_r[g]);
            assign rise  = agree && s3_r[g] && !lvl_r[g];
            assign fall  = agree && !s3_r[g] && lvl_r[g];
            // Level accepted only on agreement, filters one-cycle glitches
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    lvl_r[g] <= 1'b0;
                end else if (agree) begin
                    lvl_r[g] <= s3_r[g];
                end
            end
            // Set wins over clear so a coincident edge is kept
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pend_r[g] <= 1'b0;
                end else if ((rise && eif.rise_en[g]) || (fall && eif.fall_en[g])) begin
                    pend_r[g] <= 1'b1;   // see R11
                end else if (eif.clr[g]) begin
                    pend_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign eif.pend = pend_r;
endmodule

// File: design/vic_edge_if.sv
// Interface between the controller core and the port edge detector
`timescale 1ns/1ps
interface vic_edge_if #(parameter int W = 46);
    logic [W-1:0] rise_en;   // Detect rising edges
    logic [W-1:0] fall_en;   // Detect falling edges
    logic [W-1:0] clr;       // One-cycle clear strobes
    logic [W-1:0] pend;      // Sticky edge status
    modport ctrl (output rise_en, output fall_en, output clr, input pend);
    modport det  (input rise_en, input fall_en, input clr, output pend);
endinterface

// File: design/vic_pkg.sv
// Package of register map, reset values and widths for the vectored interrupt controller
package vic_pkg;
    // ==========================================================
    // Widths and the merged edge channel
    localparam int          NUM_SRC       = 32;        // Request inputs
    localparam int          PIN_W         = 46;        // Edge-capable port pins
    localparam int          PRIO_W        = 4;         // Priority level width
    localparam int          ADDR_W        = 12;        // Byte address width
    localparam int          EXT3_CHAN     = 17;        // Channel fed by merged edge line
    // ==========================================================
    // Register byte offsets and table pages
    localparam logic [11:0] OFS_RAW       = 12'h000;   // Raw merged requests, ro
    localparam logic [11:0] OFS_FAST_ST   = 12'h004;   // Active fast-class sources, ro
    localparam logic [11:0] OFS_NORM_ST   = 12'h008;   // Active vectored sources, ro
    localparam logic [11:0] OFS_ENABLE    = 12'h00C;   // Source enables, rw
    localparam logic [11:0] OFS_CLASS     = 12'h010;   // 1 = fast class, rw
    localparam logic [11:0] OFS_HANDLER   = 12'h014;   // Winning handler address, ro
    localparam logic [11:0] OFS_DEF_ADDR  = 12'h018;   // Handler when none pending, rw
    localparam logic [11:0] OFS_EDGE_ST0  = 12'h020;   // Sticky edge status, ro
    localparam logic [11:0] OFS_EDGE_ST1  = 12'h024;
    localparam logic [11:0] OFS_EDGE_CLR0 = 12'h028;   // Write 1 to clear, wo
    localparam logic [11:0] OFS_EDGE_CLR1 = 12'h02C;
    localparam logic [11:0] OFS_EDGE_EN0  = 12'h030;   // Edge status enables, rw
    localparam logic [11:0] OFS_EDGE_EN1  = 12'h034;
    localparam logic [11:0] OFS_RISE0     = 12'h038;   // Rising-edge select, rw
    localparam logic [11:0] OFS_RISE1     = 12'h03C;
    localparam logic [11:0] OFS_FALL0     = 12'h040;   // Falling-edge select, rw
    localparam logic [11:0] OFS_FALL1     = 12'h044;
    localparam logic [3:0]  PAGE_VECT     = 4'h1;      // 0x100 + 4n: handler address n
    localparam logic [3:0]  PAGE_PRIO     = 4'h2;      // 0x200 + 4n: priority n
    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    localparam logic [3:0]  RST_PRIO      = 4'hF;      // Lowest priority
endpackage

// File: design/vic_top.sv
// Vectored interrupt controller with Wishbone registers and port edge merge
// What this block does
// R1 - Thirty-two inputs, each classed fast or vectored
// R2 - Non-fast inputs are vectored with own priority
// R3 - Fast requests bypass all vectored arbitration
// R4 - Fast output is OR of active fast
// R5 - Readable word of active fast sources
// R6 - Priorities writable at run time
// R7 - Equal priority: lowest channel wins
// R8 - Normal output is OR of active vectored
// R9 - Readable handler address of the winner
// R10 - Each peripheral drives one merged line
// R11 - Port pins trigger on rise, fall, both
// R12 - Port edges OR into external line three
// R13 - Outputs held while any request stays active
`timescale 1ns/1ps
module vic_top #(
    parameter int NUM_SRC = vic_pkg::NUM_SRC,
    parameter int PIN_W   = vic_pkg::PIN_W
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // Wishbone classic slave
    input  wire logic               wb_cyc_in,
    input  wire logic               wb_stb_in,
    input  wire logic               wb_we_in,
    input  wire logic [11:0]        wb_adr_in,
    input  wire logic [3:0]         wb_sel_in,
    input  wire logic [31:0]        wb_dat_in,
    output logic      [31:0]        wb_dat_out,
    output logic                    wb_ack_out,
    // Request sources and port pins
    input  wire logic [NUM_SRC-1:0] irq_src_in,
    input  wire logic               ext_int_line_three_in,
    input  wire logic [PIN_W-1:0]   port_pins_in,
    // Processor requests
    output logic                    fast_interrupt_request_out,
    output logic                    normal_request_out,
    output logic                    ext_int_line_three_out
);
    // ==========================================================
    // Register state
    logic [31:0]              enable_r;     // Source enables
    logic [31:0]              class_r;      // 1 = fast class
    logic [31:0]              def_addr_r;   // Handler when nothing pending
    logic [31:0]              handler_r;    // Winning handler address
    logic [31:0]              vect_r [NUM_SRC];  // Handler address table
    logic [3:0]               prio_r [NUM_SRC];  // Priority per source, 0 highest
    logic [63:0]              rise_r;       // Rising-edge selects
    logic [63:0]              fall_r;       // Falling-edge selects
    logic [63:0]              edge_en_r;    // Edge status enables
    logic [63:0]              edge_clr;     // Clear strobes this cycle
    logic [31:0]              rd_nxt;       // Read data next
    logic                     fast_r;
    logic                     norm_r;
    logic                     ext3_r;
    logic                     ack_r;
    logic [31:0]              dat_r;

    vic_edge_if #(.W(PIN_W)) eif ();

    // ==========================================================
    // Edge detector
    vic_edge_det #(.W(PIN_W)) u_edge (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .pins_in  (port_pins_in),
        .eif      (eif.det)
    );
    // Select words are 64 bits wide; bits above the last pin are spare
    assign eif.rise_en = rise_r[PIN_W-1:0];
    assign eif.fall_en = fall_r[PIN_W-1:0];
    assign eif.clr     = edge_clr[PIN_W-1:0];

    // ==========================================================
    // Request merge
    logic [63:0]        pend_w;        // Edge status padded to two words
    logic               edge_any;      // Any enabled edge pending
    logic [31:0]        raw;           // Merged request word
    logic [31:0]        fast_act;      // Active fast-class requests
    logic [31:0]        norm_act;      // Active vectored requests
    // Pad so both status words read back with zero spare bits
    assign pend_w   = {{(64-PIN_W){1'b0}}, eif.pend};
    assign edge_any = |(pend_w & edge_en_r);
    // Edge line joins the external line on its one channel
    assign raw      = irq_src_in
                    | ({31'h0, ext_int_line_three_in | edge_any} << vic_pkg::EXT3_CHAN); // see R12
    assign fast_act = raw & enable_r & class_r;    // see R1
    assign norm_act = raw & enable_r & ~class_r;   // see R2

    // ==========================================================
    // Priority arbitration over vectored requests
    logic [4:0]         win_idx;       // Winning channel
    logic [3:0]         win_pri;       // Its priority
    logic               win_any;       // Any vectored request
    // Strict compare from channel 0 upward keeps the lowest index on ties
    always_comb begin
        win_idx = 5'h00;
        win_pri = 4'hF;
        win_any = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (norm_act[i] && (!win_any || prio_r[i] < win_pri)) begin // see R7
                win_idx = 5'(i);
                win_pri = prio_r[i];
                win_any = 1'b1;
            end
        end
    end

    // ==========================================================
    // Processor request outputs, held while any source stays active
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fast_r <= 1'b0;
            norm_r <= 1'b0;
            ext3_r <= 1'b0;
        end else begin
            fast_r <= |fast_act;    // see R3, R4, R13
            norm_r <= |norm_act;    // see R8, R13
            ext3_r <= edge_any;
        end
    end

    // Handler address follows the current winner, one cycle behind
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            handler_r <= vic_pkg::RST_WORD;
        end else begin
            handler_r <= win_any ? vect_r[win_idx] : def_addr_r;  // see R9
        end
    end

    // ==========================================================
    // Wishbone decode
    logic               req;           // New access this cycle
    logic               wr;            // Write strobe
    logic [31:0]        wmask;         // Byte lane mask
    logic [3:0]         page;          // Table page
    logic [4:0]         ent;           // Table entry
    // Ack blocks a second take while the master still holds cyc
    assign req   = wb_cyc_in && wb_stb_in && !ack_r;
    assign wr    = req && wb_we_in;
    assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    assign page  = wb_adr_in[11:8];
    assign ent   = wb_adr_in[6:2];

    // Merge written bytes into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // Clear strobes last one cycle, only the written lanes count
    always_comb begin
        edge_clr = 64'h0;
        if (wr && wb_adr_in == vic_pkg::OFS_EDGE_CLR0) begin
            edge_clr[31:0] = wb_dat_in & wmask;
        end else if (wr && wb_adr_in == vic_pkg::OFS_EDGE_CLR1) begin
            edge_clr[63:32] = wb_dat_in & wmask;
        end
    end

    // Control words
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_r   <= vic_pkg::RST_WORD;
            class_r    <= vic_pkg::RST_WORD;
            def_addr_r <= vic_pkg::RST_WORD;
            rise_r     <= {2{vic_pkg::RST_WORD}};
            fall_r     <= {2{vic_pkg::RST_WORD}};
            edge_en_r  <= {2{vic_pkg::RST_WORD}};
        end else if (wr) begin
            unique case (wb_adr_in)
                vic_pkg::OFS_ENABLE:   enable_r   <= merge(enable_r, wb_dat_in, wmask);
                vic_pkg::OFS_CLASS:    class_r    <= merge(class_r, wb_dat_in, wmask); // see R1
                vic_pkg::OFS_DEF_ADDR: def_addr_r <= merge(def_addr_r, wb_dat_in, wmask);
                vic_pkg::OFS_RISE0:    rise_r[31:0]  <= merge(rise_r[31:0], wb_dat_in, wmask);
                vic_pkg::OFS_RISE1:    rise_r[63:32] <= merge(rise_r[63:32], wb_dat_in, wmask);
                vic_pkg::OFS_FALL0:    fall_r[31:0]  <= merge(fall_r[31:0], wb_dat_in, wmask);
                vic_pkg::OFS_FALL1:    fall_r[63:32] <= merge(fall_r[63:32], wb_dat_in, wmask);
                vic_pkg::OFS_EDGE_EN0: edge_en_r[31:0]  <= merge(edge_en_r[31:0], wb_dat_in, wmask);
                vic_pkg::OFS_EDGE_EN1: edge_en_r[63:32] <= merge(edge_en_r[63:32], wb_dat_in, wmask);
                default: ;   // Other offsets handled elsewhere or ignored
            endcase
        end
    end

    // Handler and priority tables, changeable at any time
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                vect_r[i] <= vic_pkg::RST_WORD;
                prio_r[i] <= vic_pkg::RST_PRIO;
            end
        end else if (wr && page == vic_pkg::PAGE_VECT && wb_adr_in[7] == 1'b0) begin
            vect_r[ent] <= merge(vect_r[ent], wb_dat_in, wmask);
        end else if (wr && page == vic_pkg::PAGE_PRIO && wb_adr_in[7] == 1'b0
                     && wb_sel_in[0]) begin
            prio_r[ent] <= wb_dat_in[3:0];   // see R6
        end
    end

    // ==========================================================
    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_nxt = 32'h0;
        if (page == vic_pkg::PAGE_VECT && !wb_adr_in[7]) begin
            rd_nxt = vect_r[ent];
        end else if (page == vic_pkg::PAGE_PRIO && !wb_adr_in[7]) begin
            rd_nxt = {28'h0, prio_r[ent]};
        end else begin
            unique case (wb_adr_in)
                vic_pkg::OFS_RAW:      rd_nxt = raw;
                vic_pkg::OFS_FAST_ST:  rd_nxt = fast_act;   // see R5
                vic_pkg::OFS_NORM_ST:  rd_nxt = norm_act;
                vic_pkg::OFS_ENABLE:   rd_nxt = enable_r;
                vic_pkg::OFS_CLASS:    rd_nxt = class_r;
                vic_pkg::OFS_HANDLER:  rd_nxt = handler_r;  // see R9
                vic_pkg::OFS_DEF_ADDR: rd_nxt = def_addr_r;
                vic_pkg::OFS_EDGE_ST0: rd_nxt = pend_w[31:0];
                vic_pkg::OFS_EDGE_ST1: rd_nxt = pend_w[63:32];
                vic_pkg::OFS_EDGE_EN0: rd_nxt = edge_en_r[31:0];
                vic_pkg::OFS_EDGE_EN1: rd_nxt = edge_en_r[63:32];
                vic_pkg::OFS_RISE0:    rd_nxt = rise_r[31:0];
                vic_pkg::OFS_RISE1:    rd_nxt = rise_r[63:32];
                vic_pkg::OFS_FALL0:    rd_nxt = fall_r[31:0];
                vic_pkg::OFS_FALL1:    rd_nxt = fall_r[63:32];
                default:               rd_nxt = 32'h0;
            endcase
        end
    end

    // One-cycle answer; ack drops the cycle after it was given
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
            dat_r <= vic_pkg::RST_WORD;
        end else begin
            ack_r <= req;
            dat_r <= (req && !wb_we_in) ? rd_nxt : 32'h0;
        end
    end

    assign wb_ack_out                 = ack_r;
    assign wb_dat_out                 = dat_r;
    assign fast_interrupt_request_out = fast_r;
    assign normal_request_out         = norm_r;
    assign ext_int_line_three_out     = ext3_r;

    // ==========================================================
    // Checks
    // A new fast request reaches the core one edge later
    chk_fast_or_out: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R4
        $rose(|fast_act) |=> fast_interrupt_request_out)
        else $error("fast output missed an active fast request");

    // Two quiet cycles leave no stale fast request behind
    chk_fast_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R13
        (fast_act == 32'h0) [*2] |-> !fast_interrupt_request_out)
        else $error("fast output held with no fast request");

    // A held vectored request keeps the normal line up
    chk_norm_or_out: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R8
        (|norm_act) [*2] |-> normal_request_out)
        else $error("normal output low with vectored request active");

    // Fast-class traffic alone must never raise the normal line
    chk_class_split: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R1
        (|fast_act) && ((raw & enable_r & ~class_r) == 32'h0) |=> !normal_request_out)
        else $error("fast-class source raised the normal output");

    // Fast requests bypass arbitration and need no vectored winner
    chk_fast_no_norm: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R3
        (norm_act == 32'h0) && (|fast_act) |=> fast_interrupt_request_out && !normal_request_out)
        else $error("fast request routed to normal output");

    // Channel zero wins any tie it takes part in
    chk_win_tie: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R7
        win_any |-> (win_idx == 5'h00 || !(norm_act[0] && prio_r[0] == win_pri)))
        else $error("tie not given to lowest channel");

    // Nothing of lower urgency beats an active channel zero
    chk_win_prio: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R2
        win_any && norm_act[0] |-> win_pri <= prio_r[0])
        else $error("winner has lower priority than channel zero");

    // With a steady winner the handler word matches its table entry
    chk_handler_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R9
        win_any ##1 $stable(win_idx) && $stable(vect_r[win_idx]) |-> handler_r == vect_r[win_idx])
        else $error("handler register not the winner address");

    // A priority write is visible on the following edge
    chk_prio_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R6
        wr && page == vic_pkg::PAGE_PRIO && !wb_adr_in[7] && wb_sel_in[0]
        |=> prio_r[$past(ent)] == $past(wb_dat_in[3:0]))
        else $error("priority write lost");

    // A pending pin edge shows on its own line and, if enabled, as a vectored request
    chk_edge_merge: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R12
        edge_any && enable_r[vic_pkg::EXT3_CHAN] && !class_r[vic_pkg::EXT3_CHAN]
        |=> normal_request_out && ext_int_line_three_out)
        else $error("edge status not merged onto line three");

    // Classic cycle: ack is a single pulse, never a level
    chk_ack_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
endmodule

// File: verification/vec_core_model.sv
// Behavioural processor core that watches the two request lines
`timescale 1ns/1ps
module vec_core_model (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic fast_in,
    input  wire logic normal_in,
    output int        fast_cnt_out,
    output int        normal_cnt_out
);
    logic fast_r;   // Previous fast level
    logic norm_r;   // Previous normal level
    // ==========================================================
    // Entry counting
    // Counts rising levels as handler entries; a level that stays
    // high is one entry only, as a real core would see it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fast_r         <= 1'b0;
            norm_r         <= 1'b0;
            fast_cnt_out   <= 0;
            normal_cnt_out <= 0;
        end else begin
            fast_r <= fast_in;
            norm_r <= normal_in;
            if (fast_in && !fast_r) begin
                fast_cnt_out <= fast_cnt_out + 1;
            end
            if (normal_in && !norm_r) begin
                normal_cnt_out <= normal_cnt_out + 1;
            end
        end
    end
endmodule

// File: verification/vectored_interrupt_controller_test.sv
// Self-checking bench of the interrupt controller top
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("ERROR t=%0t got %h want %h", $time, (a), (e)); end end
module vectored_interrupt_controller_test;
    // ==========================================================
    // Signals
    logic        clk_in, rst_n_in;               // Clock, reset
    logic        cyc, stb, we;                   // Bus request
    logic [11:0] adr;                            // Byte address
    logic [3:0]  sel;                            // Byte lanes
    logic [31:0] wdat, rdat, q;                  // Bus data
    logic        ack, fast, norm, ext3_out;      // Design outputs
    logic [31:0] src;                            // Peripheral lines
    logic        ext3;                           // External line three
    logic [45:0] pins;                           // Port pins
    int          failures, cmp_count, cyc_cnt;   // Bookkeeping
    int          fast_cnt, norm_cnt;             // Core entries
    vic_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .irq_src_in(src),
        .ext_int_line_three_in(ext3), .port_pins_in(pins),
        .fast_interrupt_request_out(fast), .normal_request_out(norm),
        .ext_int_line_three_out(ext3_out));
    vec_core_model core_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .fast_in(fast),
        .normal_in(norm), .fast_cnt_out(fast_cnt), .normal_cnt_out(norm_cnt));
    // ==========================================================
    // Clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // Whole run is under two hundred cycles; this ceiling leaves wide margin
    always @(posedge clk_in) begin
        cyc_cnt++;
        if (cyc_cnt > 5000) begin
            $display("ERROR t=%0t run did not finish in time", $time);
            failures++;
            finish_test();
        end
    end
    // ==========================================================
    // Shared tasks
    // One classic cycle; held until ack is sampled, then released
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do begin
            @(posedge clk_in);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_in);
    endtask
    // Waits cycles for registered outputs to settle
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic finish_test();
        $display("failures=%0d compares=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // Reset values and an unmapped place
    task automatic t_reset();
        bus(0, vic_pkg::OFS_ENABLE, 0);  `CHK(q, vic_pkg::RST_WORD)
        bus(0, 12'h204, 0);              `CHK(q[3:0], 4'hF)
        bus(1, 12'h080, 32'h1234_5678);
        bus(0, 12'h080, 0);              `CHK(q, 32'h0)
    endtask
    // Two fast sources beside one vectored source
    task automatic t_fast();
        bus(1, vic_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
        bus(1, vic_pkg::OFS_CLASS, 32'h5);
        src <= 32'hD;            // Each peripheral drives one line
        wt(3);                   `CHK({fast, norm}, 2'b11)
        bus(0, vic_pkg::OFS_FAST_ST, 0); `CHK(q, 32'h5)
        src <= 32'h4;
        wt(3);                   `CHK({fast, norm}, 2'b10)
        src <= 32'h0;
        wt(3);                   `CHK(fast, 1'b0)
        bus(1, vic_pkg::OFS_CLASS, 32'h0);
    endtask
    // Equal priority tie, then a run-time priority change
    task automatic t_vect();
        bus(1, 12'h10C, 32'h300);
        bus(1, 12'h114, 32'h500);
        bus(1, vic_pkg::OFS_DEF_ADDR, 32'hDEF);
        bus(1, 12'h20C, 32'h2);
        bus(1, 12'h214, 32'h2);
        src <= 32'h28;
        wt(3);                   `CHK(norm, 1'b1)
        bus(0, vic_pkg::OFS_HANDLER, 0); `CHK(q, 32'h300)
        bus(1, 12'h214, 32'h1);
        wt(2);
        bus(0, vic_pkg::OFS_HANDLER, 0); `CHK(q, 32'h500)
        src <= 32'h0;
        wt(3);                   `CHK(norm, 1'b0)
        bus(0, vic_pkg::OFS_HANDLER, 0); `CHK(q, 32'hDEF)
    endtask
    // Pin edges, rising and falling, merged onto channel 17
    task automatic t_edge();
        bus(1, vic_pkg::OFS_RISE1, 32'h100);
        bus(1, vic_pkg::OFS_FALL0, 32'h4);
        bus(1, vic_pkg::OFS_EDGE_EN0, 32'h4);
        bus(1, vic_pkg::OFS_EDGE_EN1, 32'h100);
        pins[2] <= 1'b1;         // Rising edge not selected here
        wt(10);                  `CHK(ext3_out, 1'b0)
        pins[40] <= 1'b1;
        wt(10);                  `CHK({ext3_out, norm}, 2'b11)
        bus(0, vic_pkg::OFS_EDGE_ST1, 0); `CHK(q, 32'h100)
        bus(1, vic_pkg::OFS_EDGE_CLR1, 32'h100);
        wt(4);                   `CHK({ext3_out, norm}, 2'b00)
        pins[2] <= 1'b0;
        wt(10);
        bus(0, vic_pkg::OFS_EDGE_ST0, 0); `CHK(q, 32'h4)
        bus(1, vic_pkg::OFS_EDGE_CLR0, 32'h4);
        ext3 <= 1'b1;
        wt(4);                   `CHK(norm, 1'b1)
        bus(0, vic_pkg::OFS_RAW, 0); `CHK(q[17], 1'b1)
        ext3 <= 1'b0;
        wt(4);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst_n_in = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000;
        sel = 4'h0; wdat = 32'h0; src = 32'h0; ext3 = 1'b0; pins = 46'h0;
        failures = 0; cmp_count = 0; cyc_cnt = 0;
        wt(5);
        rst_n_in <= 1'b1;
        wt(1);
        t_reset();
        t_fast();
        t_vect();
        t_edge();
        `CHK(fast_cnt, 1)
        `CHK(norm_cnt, 5)
        finish_test();
    end
endmodule
